// *** hw/rcf_flags.sv ***
`timescale 1ns/1ps
`include "rcf_consts.svh"

// Behaviour
// - a software read while the core runs and the pin is high returns the flags, then clears every flag not set by a new internal reset in the same cycle
// - each internal reset sets the flag belonging to its own source
// - unread flags from earlier internal resets stay set beside the new one
// - the illicit access flag is set only by an illicit memory access reset
module rcf_flags (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ext_reset_pin_n,
	input wire logic [`RCF_SRC_N-1:0] cause_req,
	input wire logic flags_rd,
	output logic [`RCF_FLAG_W-1:0] flags_rd_data,
	output logic flags_rd_valid,
	output logic [`RCF_FLAG_W-1:0] reset_cause_flags,
	output logic illicit_access_reset_flag,
	output logic core_reset
);

	// ==========================================
	// helpers

	// rising edge of each request line
	function automatic rcf_pkg::rcf_src_t rcf_rise(
		input rcf_pkg::rcf_src_t cur,
		input rcf_pkg::rcf_src_t prev
	);
		rcf_rise = cur & ~prev;
	endfunction : rcf_rise

	// place source events on their flag positions
	function automatic rcf_pkg::rcf_flags_t rcf_place(
		input rcf_pkg::rcf_src_t src
	);
		rcf_pkg::rcf_flags_t f;
		f = `RCF_FLAGS_RST;
		f[`RCF_BIT_WDOG] = src[`RCF_BIT_WDOG];
		f[`RCF_BIT_IAW] = src[`RCF_BIT_IAW];
		f[`RCF_BIT_RAMPAR] = src[`RCF_BIT_RAMPAR];
		f[`RCF_BIT_ILLOP] = src[`RCF_BIT_ILLOP];
		f[`RCF_BIT_VDET] = src[`RCF_BIT_VDET];
		rcf_place = f;
	endfunction : rcf_place

	// ==========================================
	// declarations
	rcf_pkg::rcf_state_t state_r;
	rcf_pkg::rcf_state_t state_nxt;
	rcf_pkg::rcf_cnt_t cnt_r;
	rcf_pkg::rcf_cnt_t cnt_nxt;
	rcf_pkg::rcf_flags_t flags_r;
	rcf_pkg::rcf_flags_t flags_nxt;
	rcf_pkg::rcf_flags_t rd_data_r;
	rcf_pkg::rcf_src_t cause_q_r;
	logic rd_valid_r;
	logic core_reset_r;
	logic iaw_r;
	logic pin_n_s;
	logic pin_low;
	logic [`RCF_SRC_N-1:0] cause_rise;
	logic any_cause;
	logic rd_take;
	logic cnt_done;
	rcf_pkg::rcf_flags_t set_vec;
	rcf_pkg::rcf_flags_t keep_vec;

	// ==========================================
	// pin synchronisation
	rcf_sync2 u_pin_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin_in(ext_reset_pin_n),
		.pin_sync(pin_n_s)
	);

	assign pin_low = ~pin_n_s;

	// ==========================================
	// internal reset source events

	// remember last request levels for edge detection
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cause_q_r <= `RCF_SRC_N'(0);
		end else begin
			cause_q_r <= cause_req;
		end
	end

	// one event per new request, any number at once
	assign cause_rise = rcf_rise(cause_req, cause_q_r);
	assign any_cause = |cause_rise;

	// ==========================================
	// read decode

	// reads count only while the core runs
	assign rd_take = flags_rd && (state_r == rcf_pkg::RCF_ST_RUN) && !pin_low;

	// ==========================================
	// flag update

	// illicit flag only from its own source line
	assign set_vec = rcf_place(cause_rise);

	assign keep_vec = rd_take ? `RCF_FLAGS_RST : flags_r;

	// pin clears all
	// set wins over the read clear, the pin wins over everything
	assign flags_nxt = pin_low ? `RCF_FLAGS_RST : (keep_vec | set_vec);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flags_r <= `RCF_FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ==========================================
	// read data capture

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_data_r <= `RCF_FLAGS_RST;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_take;
			if (rd_take) begin
				rd_data_r <= flags_r;
			end
		end
	end

	// ==========================================
	// core reset sequencer

	assign cnt_done = (cnt_r == `RCF_CNT_ZERO);

	// next state: pin holds the core, a cause stretches a reset pulse
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			rcf_pkg::RCF_ST_RUN: begin
				if (pin_low) begin
					state_nxt = rcf_pkg::RCF_ST_PIN;
				end else if (any_cause) begin
					state_nxt = rcf_pkg::RCF_ST_HOLD;
					cnt_nxt = `RCF_CNT_W'(`RCF_HOLD_CYC - 1);
				end
			end
			rcf_pkg::RCF_ST_HOLD: begin
				if (pin_low) begin
					state_nxt = rcf_pkg::RCF_ST_PIN;
				end else if (any_cause) begin
					cnt_nxt = `RCF_CNT_W'(`RCF_HOLD_CYC - 1);
				end else if (cnt_done) begin
					state_nxt = rcf_pkg::RCF_ST_RUN;
				end else begin
					cnt_nxt = cnt_r - `RCF_CNT_W'(1);
				end
			end
			rcf_pkg::RCF_ST_PIN: begin
				// stretch again once the pin rises
				if (!pin_low) begin
					state_nxt = rcf_pkg::RCF_ST_HOLD;
					cnt_nxt = `RCF_CNT_W'(`RCF_HOLD_CYC - 1);
				end
			end
			default: begin
				state_nxt = rcf_pkg::RCF_ST_HOLD;
				cnt_nxt = `RCF_CNT_W'(`RCF_HOLD_CYC - 1);
			end
		endcase
	end

	// state, counter and registered core reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= rcf_pkg::RCF_ST_PIN;
			cnt_r <= `RCF_CNT_ZERO;
			core_reset_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			core_reset_r <= (state_nxt != rcf_pkg::RCF_ST_RUN);
		end
	end

	// ==========================================
	// illicit access output

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			iaw_r <= 1'b0;
		end else begin
			iaw_r <= flags_nxt[`RCF_BIT_IAW];
		end
	end

	// ==========================================
	// outputs
	assign flags_rd_data = rd_data_r;
	assign flags_rd_valid = rd_valid_r;
	assign reset_cause_flags = flags_r;
	assign illicit_access_reset_flag = iaw_r;
	assign core_reset = core_reset_r;

endmodule : rcf_flags

// *** hw/rcf_consts.svh ***
`ifndef RCF_CONSTS_SVH
`define RCF_CONSTS_SVH

// ==========================================
// register layout
`define RCF_FLAG_W 8
`define RCF_SRC_N 5
`define RCF_FLAGS_RST 8'h00
`define RCF_SRC_PAD 3'h0

// ==========================================
// flag positions, one per internal reset source
`define RCF_BIT_WDOG 0
`define RCF_BIT_IAW 1
`define RCF_BIT_RAMPAR 2
`define RCF_BIT_ILLOP 3
`define RCF_BIT_VDET 4

// ==========================================
// core reset stretch
`define RCF_CLK_MHZ 40
`define RCF_HOLD_NS 400
`define RCF_HOLD_CYC ((`RCF_HOLD_NS * `RCF_CLK_MHZ + 999) / 1000)
`define RCF_CNT_W 5
`define RCF_CNT_ZERO 5'h00
`define RCF_PIN_IDLE 1'h1

`endif

// *** hw/rcf_pkg.sv ***
`include "rcf_consts.svh"

// ==========================================
// shared types
package rcf_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		RCF_ST_RUN = 2'b00,
		RCF_ST_HOLD = 2'b01,
		RCF_ST_PIN = 2'b10
	} rcf_state_t;

	typedef logic [`RCF_FLAG_W-1:0] rcf_flags_t;
	typedef logic [`RCF_SRC_N-1:0] rcf_src_t;
	typedef logic [`RCF_CNT_W-1:0] rcf_cnt_t;
endpackage : rcf_pkg

// *** hw/rcf_sync2.sv ***
`timescale 1ns/1ps
`include "rcf_consts.svh"

// ==========================================
// two flop synchroniser for the reset pin
module rcf_sync2 (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_r;
	logic sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			meta_r <= `RCF_PIN_IDLE;
			sync_r <= `RCF_PIN_IDLE;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign pin_sync = sync_r;
endmodule : rcf_sync2

// *** verification/rcf_flags_assertions.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker for the flag block
module rcf_flags_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ext_reset_pin_n,
	input wire logic [4:0] cause_req,
	input wire logic flags_rd,
	input wire logic [7:0] flags_rd_data,
	input wire logic flags_rd_valid,
	input wire logic [7:0] reset_cause_flags,
	input wire logic illicit_access_reset_flag,
	input wire logic core_reset
);
	logic [4:0] prev_r;
	wire [4:0] rise = cause_req & ~prev_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// request history for edge finding
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) prev_r <= 5'h00;
		else prev_r <= cause_req;
	end
	property p_rd_clr;
		ext_reset_pin_n[*3] ##0 (flags_rd && !core_reset && rise == 5'h00 && $past(rise) == 5'h00)
		|=> flags_rd_valid && flags_rd_data == $past(reset_cause_flags) && reset_cause_flags == 8'h00;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read did not clear");
	property p_set;
		ext_reset_pin_n[*3] ##0 rise != 5'h00 |=> (reset_cause_flags[4:0] & $past(rise)) == $past(rise);
	endproperty
	a_set: assert property (p_set) else $error("cause flag not set");
	property p_keep;
		ext_reset_pin_n[*3] ##0 !flags_rd
		|=> (reset_cause_flags & $past(reset_cause_flags)) == $past(reset_cause_flags);
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost without read");
	property p_iaw;
		!rise[1] |=> !$rose(illicit_access_reset_flag) && illicit_access_reset_flag == reset_cause_flags[1];
	endproperty
	a_iaw: assert property (p_iaw) else $error("illicit flag wrong");
	property p_pin;
		!ext_reset_pin_n[*3] |=> reset_cause_flags == 8'h00 && core_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin did not clear");
	c_rd: cover property (flags_rd_valid && flags_rd_data != 8'h00);
	c_multi: cover property ($countones(reset_cause_flags) > 1);
	c_pin: cover property (!ext_reset_pin_n[*3]);
endmodule : rcf_flags_checker

bind rcf_flags rcf_flags_checker u_chk (.ref_clk, .reset, .ext_reset_pin_n, .cause_req,
	.flags_rd, .flags_rd_data, .flags_rd_valid, .reset_cause_flags,
	.illicit_access_reset_flag, .core_reset);

// *** verification/reset_cause_flag_logic_bench.sv ***
`timescale 1ns/1ps
// ==========================================
// bench for the reset cause flags
module reset_cause_flag_logic_bench;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic ext_reset_pin_n = 1'b1;
	logic [4:0] cause_req = 5'h00;
	logic flags_rd = 1'b0;
	logic [7:0] flags_rd_data, reset_cause_flags, exp;
	logic flags_rd_valid, illicit_access_reset_flag, core_reset;
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 32'h2c74;
	logic [31:0] r;
	rcf_flags dut (.ref_clk, .reset, .ext_reset_pin_n, .cause_req, .flags_rd,
		.flags_rd_data, .flags_rd_valid, .reset_cause_flags,
		.illicit_access_reset_flag, .core_reset);
	// clock source
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	// expected flags after a new internal reset
	function automatic logic [7:0] exp_set(input logic [7:0] old, input logic [4:0] c);
		exp_set = old | {3'h0, c};
	endfunction : exp_set
	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	// bounded wait for core release
	task automatic wait_core();
		int i = 0;
		while (core_reset !== 1'b0 && i < 60) begin
			tick(1);
			i++;
		end
		if (i == 60) begin
			error_cnt++;
			end_of_test();
		end
	endtask : wait_core
	// pulse a cause, try a read while held
	task automatic cause(input logic [4:0] c);
		cause_req = c;
		tick(1);
		cause_req = 5'h00;
		flags_rd = 1'b1;
		exp = exp_set(exp, c);
		tick(1);
		flags_rd = 1'b0;
		chk(reset_cause_flags, exp);
		chk({7'h0, flags_rd_valid}, 8'h00);
		chk({7'h0, core_reset}, 8'h01);
		wait_core();
	endtask : cause
	// read and clear
	task automatic rd();
		chk({7'h0, illicit_access_reset_flag}, {7'h0, exp[1]});
		flags_rd = 1'b1;
		tick(1);
		flags_rd = 1'b0;
		chk(flags_rd_data, exp);
		chk({7'h0, flags_rd_valid}, 8'h01);
		chk(reset_cause_flags, 8'h00);
		exp = 8'h00;
		tick(1);
	endtask : rd
	// main sequence
	initial begin
		exp = 8'h00;
		tick(12);
		reset = 1'b0;
		wait_core();
		for (int k = 0; k < 5; k++) begin
			cause(5'h01 << k);
			rd();
		end
		cause(5'h01);
		cause(5'h02);
		rd();
		rd();
		for (int k = 0; k < 20; k++) begin
			r = $random(seed);
			cause(r[4:0] == 5'h00 ? 5'h04 : r[4:0]);
			if (r[5]) rd();
		end
		cause(5'h10);
		ext_reset_pin_n = 1'b0;
		tick(4);
		chk(reset_cause_flags, 8'h00);
		ext_reset_pin_n = 1'b1;
		exp = 8'h00;
		wait_core();
		rd();
		cause(5'h02);
		chk(reset_cause_flags, 8'h02);
		chk({7'h0, illicit_access_reset_flag}, 8'h01);
		rd();
		cause(5'h08);
		reset = 1'b1;
		tick(2);
		chk(reset_cause_flags, 8'h00);
		chk({7'h0, core_reset}, 8'h01);
		reset = 1'b0;
		exp = 8'h00;
		wait_core();
		rd();
		end_of_test();
	end
endmodule : reset_cause_flag_logic_bench
